/* src/sepd_pkg.sv */
package sepd_pkg;
  // Record indices delivered by the controller
  localparam logic [15:0] REC_IDX_APP = 16'h0001;
  localparam logic [15:0] REC_IDX_SAFE = 16'h0002;
  // Byte counts of each record kind
  localparam int POS_APP_LEN = 15;
  localparam int VEL_APP_LEN = 8;
  localparam int SAFE_LEN = 16;
  localparam int MAX_LEN = 16;
  // Position application record limits and defaults
  localparam logic [31:0] RANGE_DEF = 32'h2000_0000;
  localparam logic [31:0] RANGE_MIN = 32'h0000_0002;
  localparam logic [31:0] RANGE_MAX = 32'h2000_0000;
  localparam logic [31:0] NUM_DEF = 32'h0001_0000;
  localparam logic [31:0] NUM_MIN = 32'h0000_0001;
  localparam logic [31:0] NUM_MAX = 32'h0003_E800;
  localparam logic [31:0] DEN_DEF = 32'h0000_0001;
  localparam logic [31:0] DEN_MIN = 32'h0000_0001;
  localparam logic [31:0] DEN_MAX = 32'h0000_4000;
  localparam logic [15:0] WIN_DEF = 16'h03E8;
  localparam logic [15:0] WIN_MIN = 16'h0032;
  localparam logic [15:0] WIN_MAX = 16'h0FA0;
  // Velocity application record limits and defaults
  localparam logic [2:0] UNIT_MAX = 3'h3;
  localparam logic [3:0] FILT_MAX = 4'hA;
  localparam logic [15:0] VFAC_DEF = 16'h0001;
  localparam logic [15:0] VFAC_MIN = 16'h0001;
  localparam logic [15:0] VFAC_MAX = 16'h03E8;
  localparam logic [15:0] VINT_DEF = 16'h0064;
  localparam logic [15:0] VINT_MIN = 16'h0001;
  localparam logic [15:0] VINT_MAX = 16'h03E8;
  // Safety record limits and defaults
  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'hFFFE;
  localparam logic [15:0] WD_DEF = 16'h007D;
  localparam logic [15:0] WD_MIN = 16'h000A;
  localparam logic [15:0] WD_MAX = 16'h2710;
  localparam logic [7:0] BLOCK_ID_IPAR = 8'h01;
  // Safety trailer and CRC sizes in bytes per variant, and velocity input words
  localparam logic [2:0] TRAILER_BASIC = 3'h4;
  localparam logic [2:0] TRAILER_EXPANDED = 3'h5;
  localparam logic [2:0] CRC_BASIC = 3'h3;
  localparam logic [2:0] CRC_EXPANDED = 3'h4;
  localparam logic [2:0] VEL_IN_WORDS = 3'h2;

  typedef enum logic [1:0] {SEPD_SIL1, SEPD_SIL2, SEPD_SIL3, SEPD_NO_SIL} sepd_sil_e;

  // Applied position parameters
  typedef struct packed {
    logic direction_fwd;
    logic [31:0] measuring_range;
    logic [31:0] rev_numerator;
    logic [31:0] rev_denominator;
    logic [15:0] window_inc;
  } sepd_pos_s;

  // Applied velocity parameters
  typedef struct packed {
    logic [2:0] unit;
    logic [3:0] filter_level;
    logic filter_dynamic;
    logic [15:0] factor;
    logic [15:0] integ_ms;
    logic [15:0] window_inc;
    logic direction_fwd;
  } sepd_vel_s;

  // Applied safety parameters
  typedef struct packed {
    sepd_sil_e sil;
    logic expanded_protocol_variant;
    logic [7:0] block_id;
    logic [15:0] source_addr;
    logic [15:0] dest_addr;
    logic [15:0] wd_time_ms;
    logic [15:0] par_crc;
    logic [31:0] ipar_crc;
  } sepd_safe_s;

  // Cyclic frame layout for the velocity submodule
  typedef struct packed {
    logic [2:0] in_words;
    logic [2:0] out_words;
    logic [2:0] trailer_bytes;
    logic [2:0] crc_bytes;
  } sepd_layout_s;
endpackage

/* src/sepd_rec_buf.sv */
`timescale 1ns/1ns
// Collects record bytes by index; cleared at each record start
module sepd_rec_buf #(
  parameter int DEPTH = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic start, // Begin a new record
  input wire logic byte_valid, // Byte strobe
  input wire logic [7:0] byte_data, // Byte value
  output logic [DEPTH*8-1:0] bytes, // Collected bytes, byte 0 lowest
  output logic [4:0] count, // Bytes collected
  output logic overflow // More bytes than fit
);
  typedef struct packed {
    logic [DEPTH*8-1:0] mem;
    logic [4:0] cnt;
    logic ovf;
  } sepd_buf_s;

  sepd_buf_s st_reg;
  sepd_buf_s st_next;

  // Store each byte at its index
  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next = '0;
    end else if (byte_valid) begin
      if (int'(st_reg.cnt) < DEPTH) begin
        st_next.mem[st_reg.cnt[3:0]*8 +: 8] = byte_data;
        st_next.cnt = st_reg.cnt + 5'h01;
      end else begin
        st_next.ovf = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bytes = st_reg.mem;
  assign count = st_reg.cnt;
  assign overflow = st_reg.ovf;
endmodule

/* src/sepd_param_decoder.sv */
`timescale 1ns/1ns
// What this block does
// - Velocity record byte 7 bit0 sets sign
// - Position range bytes 1-4, 2..2^29
// - Numerator bytes 5-8, 1..256000
// - Denominator bytes 9-12, 1..16384
// - Window 50..4000, position 13-14, velocity 5-6
// - Velocity byte 0 bits 2-0 select unit
// - Bits 6-3 filter 0..10, bit7 filter type
// - Basic variant uses 4-byte trailer, 3-byte CRC
// - Expanded variant uses 5-byte trailer, 4-byte CRC
// - Velocity fills input words 1-2 before trailer
// - Watchdog time accepted 10..10000 ms
// - Source and destination addresses 1..65534
// - SIL is level 1, 2, 3 or none
// - Block identifier 1 demands application CRC
// - Safety parameter CRC is 16 bits
// - Application CRC is 32 bits
module sepd_param_decoder (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic rec_start, // Pulse: new record begins
  input wire logic [15:0] rec_index, // Record index, held over the record
  input wire logic rec_is_velocity, // Record targets the velocity submodule
  input wire logic rec_byte_valid, // Byte strobe
  input wire logic [7:0] rec_byte, // Record byte, in order from byte 0
  input wire logic rec_end, // Pulse: record complete
  output sepd_pkg::sepd_pos_s pos_params, // Applied position parameters
  output sepd_pkg::sepd_vel_s vel_params, // Applied velocity parameters
  output sepd_pkg::sepd_safe_s safe_params, // Applied safety parameters
  output sepd_pkg::sepd_layout_s vel_layout, // Cyclic frame layout
  output logic ipar_crc_required, // Application CRC demanded
  output logic rec_done, // Pulse: record judged
  output logic rec_ok, // Pulse with rec_done: record applied
  output logic rec_error // Sticky: last record rejected
);
  typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_CHECK} sepd_state_e;

  typedef struct packed {
    sepd_state_e state;
    logic [15:0] index;
    logic is_vel;
    sepd_pkg::sepd_pos_s pos;
    sepd_pkg::sepd_vel_s vel;
    sepd_pkg::sepd_safe_s safe;
    sepd_pkg::sepd_layout_s layout;
    logic crc_req;
    logic done;
    logic ok;
    logic err;
  } sepd_st_s;

  sepd_st_s st_reg;
  sepd_st_s st_next;
  logic [sepd_pkg::MAX_LEN*8-1:0] buf_bytes;
  logic [4:0] buf_count;
  logic buf_ovf;

  // Byte collector for the current record
  sepd_rec_buf #(
    .DEPTH(sepd_pkg::MAX_LEN)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(rec_start && st_reg.state != ST_CHECK), // Starts during the check are ignored
    .byte_valid(rec_byte_valid && st_reg.state == ST_COLLECT),
    .byte_data(rec_byte),
    .bytes(buf_bytes),
    .count(buf_count),
    .overflow(buf_ovf)
  );

  // Byte and big-endian word picks from the collected record
  function automatic logic [7:0] b8(input logic [sepd_pkg::MAX_LEN*8-1:0] m, input int i);
    b8 = m[i*8 +: 8];
  endfunction

  function automatic logic [15:0] u16(input logic [sepd_pkg::MAX_LEN*8-1:0] m, input int i);
    u16 = {m[i*8 +: 8], m[(i+1)*8 +: 8]};
  endfunction

  function automatic logic [31:0] u32(input logic [sepd_pkg::MAX_LEN*8-1:0] m, input int i);
    u32 = {u16(m, i), u16(m, i + 2)};
  endfunction

  // Decoded candidate values
  sepd_pkg::sepd_pos_s pos_c;
  sepd_pkg::sepd_vel_s vel_c;
  sepd_pkg::sepd_safe_s safe_c;
  logic pos_ok;
  logic vel_ok;
  logic safe_ok;

  // Field extraction and range checks
  always_comb begin
    pos_c.direction_fwd = buf_bytes[0];
    pos_c.measuring_range = u32(buf_bytes, 1);
    pos_c.rev_numerator = u32(buf_bytes, 5);
    pos_c.rev_denominator = u32(buf_bytes, 9);
    pos_c.window_inc = u16(buf_bytes, 13);
    pos_ok = (pos_c.measuring_range >= sepd_pkg::RANGE_MIN)
      && (pos_c.measuring_range <= sepd_pkg::RANGE_MAX)
      && (pos_c.rev_numerator >= sepd_pkg::NUM_MIN)
      && (pos_c.rev_numerator <= sepd_pkg::NUM_MAX)
      && (pos_c.rev_denominator >= sepd_pkg::DEN_MIN)
      && (pos_c.rev_denominator <= sepd_pkg::DEN_MAX)
      && (pos_c.window_inc >= sepd_pkg::WIN_MIN)
      && (pos_c.window_inc <= sepd_pkg::WIN_MAX);
    vel_c.unit = buf_bytes[2:0];
    vel_c.filter_level = buf_bytes[6:3];
    vel_c.filter_dynamic = buf_bytes[7];
    vel_c.factor = u16(buf_bytes, 1);
    vel_c.integ_ms = u16(buf_bytes, 3);
    vel_c.window_inc = u16(buf_bytes, 5);
    vel_c.direction_fwd = buf_bytes[7*8];
    vel_ok = (vel_c.unit <= sepd_pkg::UNIT_MAX)
      && (vel_c.filter_level <= sepd_pkg::FILT_MAX)
      && (vel_c.factor >= sepd_pkg::VFAC_MIN) && (vel_c.factor <= sepd_pkg::VFAC_MAX)
      && (vel_c.integ_ms >= sepd_pkg::VINT_MIN) && (vel_c.integ_ms <= sepd_pkg::VINT_MAX)
      && (vel_c.window_inc >= sepd_pkg::WIN_MIN)
      && (vel_c.window_inc <= sepd_pkg::WIN_MAX);
    // Safety record: byte0 SIL in bits 1-0, variant in bit 2; then fields
    safe_c.sil = sepd_pkg::sepd_sil_e'(buf_bytes[1:0]);
    safe_c.expanded_protocol_variant = buf_bytes[2];
    safe_c.block_id = b8(buf_bytes, 1);
    safe_c.source_addr = u16(buf_bytes, 2);
    safe_c.dest_addr = u16(buf_bytes, 4);
    safe_c.wd_time_ms = u16(buf_bytes, 6);
    safe_c.par_crc = u16(buf_bytes, 8);
    safe_c.ipar_crc = u32(buf_bytes, 10);
    safe_ok = (safe_c.source_addr >= sepd_pkg::ADDR_MIN)
      && (safe_c.source_addr <= sepd_pkg::ADDR_MAX)
      && (safe_c.dest_addr >= sepd_pkg::ADDR_MIN)
      && (safe_c.dest_addr <= sepd_pkg::ADDR_MAX)
      && (safe_c.wd_time_ms >= sepd_pkg::WD_MIN)
      && (safe_c.wd_time_ms <= sepd_pkg::WD_MAX);
  end

  // Record sequencing, judgement and apply
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.ok = 1'b0;
    unique case (st_reg.state)
      ST_IDLE: begin
        if (rec_start) begin
          st_next.state = ST_COLLECT;
          st_next.index = rec_index;
          st_next.is_vel = rec_is_velocity;
        end
      end
      ST_COLLECT: begin
        if (rec_start) begin
          st_next.index = rec_index;
          st_next.is_vel = rec_is_velocity;
        end else if (rec_end) begin
          st_next.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        st_next.state = ST_IDLE;
        st_next.done = 1'b1;
        st_next.err = 1'b1;
        if (!buf_ovf) begin
          if (st_reg.index == sepd_pkg::REC_IDX_APP) begin
            if (st_reg.is_vel && int'(buf_count) == sepd_pkg::VEL_APP_LEN && vel_ok) begin
              st_next.vel = vel_c;
              st_next.ok = 1'b1;
              st_next.err = 1'b0;
            end else if (!st_reg.is_vel && int'(buf_count) == sepd_pkg::POS_APP_LEN
                         && pos_ok) begin
              st_next.pos = pos_c;
              st_next.ok = 1'b1;
              st_next.err = 1'b0;
            end
          end else if (st_reg.index == sepd_pkg::REC_IDX_SAFE) begin
            if (int'(buf_count) == sepd_pkg::SAFE_LEN && safe_ok) begin
              st_next.safe = safe_c;
              st_next.crc_req = (safe_c.block_id == sepd_pkg::BLOCK_ID_IPAR);
              st_next.ok = 1'b1;
              st_next.err = 1'b0;
              // Trailer sizes follow the protocol variant
              st_next.layout.in_words = sepd_pkg::VEL_IN_WORDS;
              st_next.layout.out_words = '0;
              if (safe_c.expanded_protocol_variant) begin
                st_next.layout.trailer_bytes = sepd_pkg::TRAILER_EXPANDED;
                st_next.layout.crc_bytes = sepd_pkg::CRC_EXPANDED;
              end else begin
                st_next.layout.trailer_bytes = sepd_pkg::TRAILER_BASIC;
                st_next.layout.crc_bytes = sepd_pkg::CRC_BASIC;
              end
            end
          end
        end
      end
    endcase
  end

  // State register with documented defaults at reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.pos.measuring_range <= sepd_pkg::RANGE_DEF;
      st_reg.pos.rev_numerator <= sepd_pkg::NUM_DEF;
      st_reg.pos.rev_denominator <= sepd_pkg::DEN_DEF;
      st_reg.pos.window_inc <= sepd_pkg::WIN_DEF;
      st_reg.vel.factor <= sepd_pkg::VFAC_DEF;
      st_reg.vel.integ_ms <= sepd_pkg::VINT_DEF;
      st_reg.vel.window_inc <= sepd_pkg::WIN_DEF;
      st_reg.safe.sil <= sepd_pkg::SEPD_NO_SIL;
      st_reg.safe.wd_time_ms <= sepd_pkg::WD_DEF;
      st_reg.safe.source_addr <= sepd_pkg::ADDR_MIN;
      st_reg.safe.dest_addr <= sepd_pkg::ADDR_MIN;
      st_reg.layout.in_words <= sepd_pkg::VEL_IN_WORDS;
      st_reg.layout.trailer_bytes <= sepd_pkg::TRAILER_BASIC;
      st_reg.layout.crc_bytes <= sepd_pkg::CRC_BASIC;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign pos_params = st_reg.pos;
  assign vel_params = st_reg.vel;
  assign safe_params = st_reg.safe;
  assign vel_layout = st_reg.layout;
  assign ipar_crc_required = st_reg.crc_req;
  assign rec_done = st_reg.done;
  assign rec_ok = st_reg.ok;
  assign rec_error = st_reg.err;
endmodule

/* sim/sepd_param_decoder_properties.sv */
`timescale 1ns/1ns
// Timing and range checks on the decoder ports
module sepd_param_decoder_checker (
  input wire logic ref_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic rec_start, // Record begins
  input wire logic [15:0] rec_index, // Record index
  input wire logic rec_is_velocity, // Velocity target
  input wire logic rec_byte_valid, // Byte strobe
  input wire logic [7:0] rec_byte, // Byte value
  input wire logic rec_end, // Record complete
  input wire sepd_pkg::sepd_pos_s pos_params, // Position set
  input wire sepd_pkg::sepd_vel_s vel_params, // Velocity set
  input wire sepd_pkg::sepd_safe_s safe_params, // Safety set
  input wire sepd_pkg::sepd_layout_s vel_layout, // Frame layout
  input wire logic ipar_crc_required, // Application CRC needed
  input wire logic rec_done, // Record judged
  input wire logic rec_ok, // Record applied
  input wire logic rec_error // Last record rejected
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Verdict pulses
  AST_OK_IN_DONE: assert property (rec_ok |-> rec_done)
    else $error("ok without done");
  AST_DONE_ONE: assert property (rec_done |=> !rec_done)
    else $error("done longer than one cycle");
  AST_DONE_CAUSE: assert property ($rose(rec_done) |-> $past(rec_end, 2))
    else $error("done not two cycles after end");
  AST_KEEP_ON_REJECT: assert property (!rec_ok |->
    $stable(pos_params) && $stable(vel_params) && $stable(safe_params))
    else $error("parameters changed without ok");
  AST_ERR_ON_REJECT: assert property (rec_done && !rec_ok |-> ##[0:1] rec_error)
    else $error("reject without error flag");
  AST_ERR_CLEAR: assert property (rec_ok |-> ##[0:1] !rec_error)
    else $error("error flag kept after accept");
  // Derived outputs
  AST_IPAR_REQ: assert property (ipar_crc_required == (safe_params.block_id == 8'h01))
    else $error("application CRC demand wrong");
  AST_TRAILER: assert property (vel_layout.trailer_bytes ===
    (safe_params.expanded_protocol_variant ? sepd_pkg::TRAILER_EXPANDED : sepd_pkg::TRAILER_BASIC))
    else $error("trailer size wrong");
  AST_CRC_LEN: assert property (vel_layout.crc_bytes ===
    (safe_params.expanded_protocol_variant ? sepd_pkg::CRC_EXPANDED : sepd_pkg::CRC_BASIC))
    else $error("CRC size wrong");
  AST_VEL_WORDS: assert property (vel_layout.in_words == 3'h2 && vel_layout.out_words == 3'h0)
    else $error("velocity word layout wrong");
  // Applied values stay legal
  AST_POS_LIMITS: assert property (pos_params.measuring_range inside {[32'h2:32'h2000_0000]} &&
    pos_params.rev_numerator inside {[32'h1:32'h3_E800]} && pos_params.rev_denominator inside
    {[32'h1:32'h4000]} && pos_params.window_inc inside {[16'h32:16'hFA0]})
    else $error("position value out of range");
  AST_VEL_LIMITS: assert property (vel_params.unit <= 3'h3 && vel_params.filter_level <= 4'hA)
    else $error("velocity format out of range");
  AST_SAFE_LIMITS: assert property (safe_params.wd_time_ms inside {[16'hA:16'h2710]} &&
    safe_params.source_addr != 16'h0 && safe_params.dest_addr != 16'hFFFF)
    else $error("safety value out of range");
  // Main scenarios
  COV_ACCEPT: cover property (rec_done && rec_ok);
  COV_REJECT: cover property (rec_done && !rec_ok);
  COV_EXPANDED: cover property (safe_params.expanded_protocol_variant && ipar_crc_required);
endmodule

bind sepd_param_decoder sepd_param_decoder_checker i_chk (.*);

/* sim/sepd_ctrl_model.sv */
`timescale 1ns/1ns
// Controller stand-in delivering parameter records byte by byte
module sepd_ctrl_model (
  input wire logic ref_clk, // Clock
  input wire logic rec_done, // Record judged
  input wire logic rec_ok, // Record applied
  output logic rec_start, // Record begins
  output logic [15:0] rec_index, // Record index
  output logic rec_is_velocity, // Velocity target
  output logic rec_byte_valid, // Byte strobe
  output logic [7:0] rec_byte, // Byte value
  output logic rec_end, // Record complete
  output logic ok_seen // Verdict of last record
);
  // Idle levels
  initial begin
    {rec_start, rec_byte_valid, rec_end, ok_seen, rec_is_velocity} = 5'h0;
    rec_index = 16'h0000;
    rec_byte = 8'h00;
  end
  // Start, bytes with optional gaps, end, then wait for the verdict
  task automatic send(input logic [15:0] idx, input logic vel, input logic [7:0] q[$],
      input int gap);
    int i;
    rec_start <= 1'b1;
    rec_index <= idx;
    rec_is_velocity <= vel;
    @(posedge ref_clk);
    #1;
    rec_start <= 1'b0;
    foreach (q[k]) begin
      rec_byte_valid <= 1'b1;
      rec_byte <= q[k];
      @(posedge ref_clk);
      #1;
      if (gap > 0) begin
        rec_byte_valid <= 1'b0;
        rec_byte <= ~q[k];
        repeat (gap) @(posedge ref_clk);
        #1;
      end
    end
    rec_byte_valid <= 1'b0;
    rec_byte <= ~q[q.size()-1];
    rec_end <= 1'b1;
    @(posedge ref_clk);
    #1;
    rec_end <= 1'b0;
    i = 0;
    while (!rec_done && i < 10) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    ok_seen = rec_done & rec_ok;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

/* sim/sepd_param_decoder_tb_top.sv */
`timescale 1ns/1ns
// Self-checking bench for the parameter decoder
module sepd_param_decoder_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rec_start, rec_is_velocity, rec_byte_valid, rec_end, ok_seen;
  logic [15:0] rec_index;
  logic [7:0] rec_byte;
  sepd_pkg::sepd_pos_s pos_params;
  sepd_pkg::sepd_vel_s vel_params;
  sepd_pkg::sepd_safe_s safe_params;
  sepd_pkg::sepd_layout_s vel_layout;
  logic ipar_crc_required, rec_done, rec_ok, rec_error;
  int err_count = 0;
  int checked = 0;
  logic [119:0] bad_pos [5];
  logic [127:0] bad_safe [4];

  // Clock and instances
  always #5 ref_clk = ~ref_clk;
  sepd_param_decoder i_dut (.*);
  sepd_ctrl_model i_model (.*);

  // Compare and report
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Record senders, byte 0 first, fields big-endian
  task automatic send_pos(input logic [15:0] idx, input logic [119:0] p, input int gap);
    logic [7:0] q[$];
    for (int i = 0; i < 15; i++) q.push_back(p[119-8*i -: 8]);
    i_model.send(idx, 1'b0, q, gap);
  endtask
  task automatic send_vel(input logic [63:0] p);
    logic [7:0] q[$];
    for (int i = 0; i < 8; i++) q.push_back(p[63-8*i -: 8]);
    i_model.send(16'h0001, 1'b1, q, 0);
  endtask
  task automatic send_safe(input logic [127:0] p);
    logic [7:0] q[$];
    for (int i = 0; i < 16; i++) q.push_back(p[127-8*i -: 8]);
    i_model.send(16'h0002, 1'b0, q, 1);
  endtask

  // Watchdog
  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  // Test sequence
  initial begin
    bad_pos = '{{8'h0, 32'h1, 32'h1, 32'h1, 16'h3E8}, {8'h0, 32'h2000_0001, 32'h1, 32'h1, 16'h3E8},
      {8'h0, 32'h2, 32'h3_E801, 32'h1, 16'h3E8}, {8'h0, 32'h2, 32'h1, 32'h0, 16'h3E8},
      {8'h0, 32'h2, 32'h1, 32'h1, 16'h31}};
    bad_safe = '{{16'h0, 16'hFFFF, 16'h1, 16'h7D, 64'h0}, {16'h0, 16'h1, 16'h0, 16'h7D, 64'h0},
      {16'h0, 16'h1, 16'h1, 16'h2711, 64'h0}, {16'h0, 16'h1, 16'h1, 16'h9, 64'h0}};
    repeat (5) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk("range", pos_params.measuring_range, sepd_pkg::RANGE_DEF);
    chk("num", pos_params.rev_numerator, sepd_pkg::NUM_DEF);
    chk("den", pos_params.rev_denominator, sepd_pkg::DEN_DEF);
    chk("win", pos_params.window_inc, sepd_pkg::WIN_DEF);
    chk("sil", safe_params.sil, 32'h3);
    chk("wd", safe_params.wd_time_ms, 32'h7D);
    chk("layout", vel_layout, 32'h423);
    $display("reset test done");
    send_pos(16'h0001, {8'h1, 32'h2, 32'h3_E800, 32'h4000, 16'hFA0}, 0);
    chk("ok", ok_seen, 1'b1);
    chk("pos", pos_params, {1'b1, 32'h2, 32'h3_E800, 32'h4000, 16'hFA0});
    foreach (bad_pos[i]) begin
      send_pos(16'h0001, bad_pos[i], 2);
      chk("bad ok", ok_seen, 1'b0);
      chk("err", rec_error, 1'b1);
      chk("kept", pos_params.measuring_range, 32'h2);
    end
    send_pos(16'h0003, {8'h1, 32'h2, 32'h1, 32'h1, 16'h32}, 0);
    chk("index", ok_seen, 1'b0);
    $display("position test done");
    for (int u = 0; u < 4; u++) begin
      send_vel({1'b1, 4'hA, u[2:0], 48'h03E8_0001_0032, 8'h1});
      chk("vok", ok_seen, 1'b1);
      chk("vel", vel_params, {u[2:0], 4'hA, 1'b1, 48'h03E8_0001_0032, 1'b1});
      chk("err", rec_error, 1'b0);
    end
    send_vel({8'h04, 56'h1_0064_03E8_00});
    chk("unit", ok_seen, 1'b0);
    send_vel({8'h58, 56'h1_0064_03E8_00});
    chk("filt", ok_seen, 1'b0);
    $display("velocity test done");
    for (int s = 0; s < 4; s++) begin
      send_safe({5'h0, s[0], s[1:0], s[7:0], 64'hFFFE_0001_2710_ABCD, 32'hCAFE_0001, 16'h0});
      chk("sok", ok_seen, 1'b1);
      chk("sil", safe_params.sil, s);
      chk("ipar", ipar_crc_required, s == 1);
      chk("pcrc", safe_params.par_crc, 32'hABCD);
      chk("icrc", safe_params.ipar_crc, 32'hCAFE_0001);
      chk("trl", vel_layout.trailer_bytes, s[0] ? 5 : 4);
      chk("crc", vel_layout.crc_bytes, s[0] ? 4 : 3);
    end
    foreach (bad_safe[i]) begin
      send_safe(bad_safe[i]);
      chk("sbad", ok_seen, 1'b0);
      chk("kept", safe_params.source_addr, 32'hFFFE);
    end
    $display("safety test done");
    stop_test();
  end
endmodule
